//--- src/dma_pkg.sv
`default_nettype none
// Notes on behaviour
// [RQ1] fixed priority: channel 0 wins, then 1, then 2, channel 3 last
// [RQ2] rotating priority: finished channel drops to lowest, its successor becomes highest
// [RQ3] match, terminal count, end of process, error each enabled per channel command
// [RQ4] transferred data equal to match value stops channel and flags match
// [RQ5] programmed number of transfers done flags terminal count
// [RQ6] end-of-process input ends the running transfer and flags it
// [RQ7] start while count is zero: no transfer, error flagged
// [RQ8] events latch in channel flags; writing one clears a flag
// [RQ9] channels 0..2: bit 7 enables acknowledge on request
// [RQ10] channel 3 bit 7 picks rotating priority; its acknowledge acts as bit cleared
// [RQ11] mode bit2 dual/single, bit3 direction; single drives one pointer only
// [RQ12] external acknowledge: pin/software always in single, else only when enabled
// [RQ13] internal acknowledge only single, internal request, serial or converter sources
// [RQ14] software clears internal-connection bit for pin or software starts
// [RQ15] software reprograms a channel only while its enable bit is zero
// [RQ16] software gives even addresses for 16-bit transfers
// [RQ17] 24-bit source and target pointers, three bytes each
// [RQ18] 16-bit transfer count in two bytes
// [RQ19] count and compare use source width, per byte or per word
// [RQ20] 8-bit to 8-bit compares only the low match byte
// [RQ21] mode second bits 7:5 select one of eight internal request sources
// [RQ22] software sets pulse detect for pulse sources; converter uses channel 0
// [RQ23] direction bit ignored for dual-address transfers
// [RQ24] auto reload fires on any enabled event that ended the transfer
// [RQ25] software start bit starts a channel without pin activity
// [RQ26] auto reload restores count and both pointers to pre-transfer values
package dma_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int        CH_LSB      = 6;      // channel field of the byte address
   localparam int        IDX_LSB     = 2;      // word index field
   localparam logic [3:0] IDX_SRC_LOW  = 4'h0;
   localparam logic [3:0] IDX_SRC_MID  = 4'h1;
   localparam logic [3:0] IDX_SRC_HIGH = 4'h2;
   localparam logic [3:0] IDX_DST_LOW  = 4'h3;
   localparam logic [3:0] IDX_DST_MID  = 4'h4;
   localparam logic [3:0] IDX_DST_HIGH = 4'h5;
   localparam logic [3:0] IDX_CNT_LOW  = 4'h6;
   localparam logic [3:0] IDX_CNT_HIGH = 4'h7;
   localparam logic [3:0] IDX_MAT_LOW  = 4'h8;
   localparam logic [3:0] IDX_MAT_HIGH = 4'h9;
   localparam logic [3:0] IDX_MODE_A   = 4'ha;
   localparam logic [3:0] IDX_MODE_B   = 4'hb;
   localparam logic [3:0] IDX_CMD      = 4'hc;
   localparam logic [3:0] IDX_FLAGS    = 4'hd;

   // ****************************************
   // field positions
   // ****************************************
   localparam int MA_ACK_PRI = 7;   // acknowledge enable, channel 3: rotate
   localparam int MA_LEVEL   = 6;   // level_detect_select: 1 pulse, 0 level
   localparam int MA_SRC16   = 5;
   localparam int MA_DST16   = 4;
   localparam int MA_DIR     = 3;   // 0 io to memory, 1 memory to io
   localparam int MA_SINGLE  = 2;
   localparam int MB_SEL_LSB = 5;
   localparam int MB_INTCONN = 4;
   localparam int MB_SUPD    = 2;
   localparam int MB_DUPD    = 0;
   localparam int CMD_IE_LSB = 4;   // enables in flag order
   localparam int CMD_RELOAD = 3;   // auto_reload_bit
   localparam int CMD_SW     = 1;   // software_start_bit
   localparam int CMD_EN     = 0;   // channel_enable_bit
   localparam int FL_MAT     = 0;
   localparam int FL_TC      = 1;
   localparam int FL_EOP     = 2;
   localparam int FL_ERR     = 3;

   // ****************************************
   // codes and reset values
   // ****************************************
   localparam logic [1:0] XM_BYTE     = 2'h0;
   localparam logic [1:0] XM_CONTINUE = 2'h1;
   localparam logic [1:0] XM_DEMAND   = 2'h2;
   localparam logic [1:0] UPD_FIXED   = 2'h0;
   localparam logic [1:0] UPD_INC     = 2'h1;
   localparam logic [1:0] UPD_DEC     = 2'h2;
   localparam logic [2:0] SEL_ACK_LAST = 3'h4;   // codes 0..4 have internal ack
   localparam logic [3:0] FLAGS_RST   = 4'h0;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } eng_state_type;

   typedef struct packed {
      logic [7:0]  cmd;
      logic [7:0]  mode_b;
      logic [7:0]  mode_a;
      logic [15:0] mat;
      logic [15:0] cnt;
      logic [23:0] da;
      logic [23:0] sa;
   } chan_cfg_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        write;
      logic        wide;
   } bus_cmd_type;

   localparam chan_cfg_type CFG_RST = '0;
   localparam bus_cmd_type  BUS_RST = '0;

endpackage
`default_nettype wire

//--- src/dma_controller.sv
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dma_controller
   import dma_pkg::*;
#(
   parameter int APB_AW = 8
)(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  transfer_request_pin,
   input  wire logic [3:0]  end_of_process,
   input  wire logic [7:0]  internal_request,
   output logic [3:0]       transfer_acknowledge,
   output logic [7:0]       internal_acknowledge,
   output logic [3:0]       terminal_count,
   output logic [3:0]       event_irq,
   output logic             bus_req,
   output bus_cmd_type      bus_cmd,
   input  wire logic        bus_ready,
   input  wire logic [15:0] bus_rdata
);

   // ****************************************
   // elaboration checks
   // ****************************************
   if (APB_AW < 8)
   begin : g_bad_aw
      $error("APB_AW must be at least 8");
   end

   // ****************************************
   // state
   // ****************************************
   chan_cfg_type  cfg_reg  [4];
   chan_cfg_type  cfg_next [4];
   chan_cfg_type  shad_reg [4];
   chan_cfg_type  shad_next[4];
   logic [3:0]    flag_reg [4];
   logic [3:0]    flag_next[4];
   logic [3:0]    pend_reg, pend_next;
   logic [3:0]    prev_reg;
   logic [3:0]    tc_reg, tc_next;
   eng_state_type state_reg, state_next;
   logic [1:0]    cur_reg, cur_next;
   logic [1:0]    last_reg, last_next;
   bus_cmd_type   bus_reg, bus_next;
   logic [15:0]   data_reg, data_next;
   logic          eop_seen_reg, eop_seen_next;
   logic [31:0]   prdata_reg, prdata_next;

   // ****************************************
   // helper functions
   // ****************************************
   // next pointer value for one unit; io mode swings between a byte pair
   function automatic logic [23:0] upd_ptr(input logic [23:0] a, input logic [1:0] m, input logic wide);
      logic [23:0] step;
      step = wide ? 24'h000002 : 24'h000001;
      case (m)
         UPD_FIXED: upd_ptr = a;
         UPD_INC:   upd_ptr = a + step;
         UPD_DEC:   upd_ptr = a - step;
         default:   upd_ptr = {a[23:1], ~a[0]};
      endcase
   endfunction

   // first bus cycle of a unit
   function automatic bus_cmd_type first_cycle(input logic [23:0] sa, input logic [23:0] da,
                                               input logic [7:0] ma);
      bus_cmd_type b;
      b = BUS_RST;
      b.wide = ma[MA_SRC16];
      if (ma[MA_SINGLE] && !ma[MA_DIR])
      begin
         b.addr  = da;                                          // RQ11
         b.write = 1'b1;
      end
      else
      begin
         b.addr  = sa;                                          // RQ11 RQ23
      end
      first_cycle = b;
   endfunction

   // first ready channel walking up from base
   function automatic logic [2:0] pick_ch(input logic [3:0] rdy, input logic [1:0] base);
      logic [1:0] idx;
      logic [2:0] res;
      res = 3'h0;
      for (int i = 3; i >= 0; i--)
      begin
         idx = base + 2'(i);
         if (rdy[idx])
            res = {1'b1, idx};                                  // RQ1 RQ2
      end
      pick_ch = res;
   endfunction

   // ****************************************
   // request detection per channel
   // ****************************************
   logic [3:0] req_src, req_line, ch_ready;

   for (genvar c = 0; c < 4; c++)
   begin : g_req
      // internal connection steers the request line to the selected source
      assign req_src[c]  = cfg_reg[c].mode_b[MB_INTCONN] ?
                           internal_request[cfg_reg[c].mode_b[MB_SEL_LSB +: 3]] :  // RQ21
                           transfer_request_pin[c];
      // pulse sources are caught in a pending bit so a short pulse is not missed
      assign req_line[c] = cfg_reg[c].mode_a[MA_LEVEL] ? pend_reg[c] : req_src[c];
      assign ch_ready[c] = cfg_reg[c].cmd[CMD_EN] &
                           (req_line[c] | cfg_reg[c].cmd[CMD_SW]);  // RQ25
   end

   // ****************************************
   // arbitration and current channel view
   // ****************************************
   wire        rotate_on = cfg_reg[3].mode_a[MA_ACK_PRI];           // RQ10
   wire [1:0]  arb_base  = rotate_on ? last_reg + 2'd1 : 2'd0;      // RQ2 RQ1
   wire [2:0]  pick_res  = pick_ch(ch_ready, arb_base);
   wire        any_ready = pick_res[2];
   wire [1:0]  pick      = pick_res[1:0];
   chan_cfg_type cur_cfg;
   assign cur_cfg = cfg_reg[cur_reg];
   wire        busy      = (state_reg != ST_IDLE);
   wire        src16     = cur_cfg.mode_a[MA_SRC16];
   wire        single    = cur_cfg.mode_a[MA_SINGLE];
   wire [1:0]  xmode     = cur_cfg.mode_a[1:0];
   wire [23:0] nsa       = upd_ptr(cur_cfg.sa, cur_cfg.mode_b[MB_SUPD +: 2], src16);
   wire [23:0] nda       = upd_ptr(cur_cfg.da, cur_cfg.mode_b[MB_DUPD +: 2], cur_cfg.mode_a[MA_DST16]);
   wire [15:0] ncnt      = cur_cfg.cnt - 16'd1;                      // RQ19

   // ****************************************
   // engine next state
   // ****************************************
   logic       accept, err_start, unit_done, stop_now, reload_now;
   logic [3:0] ev;
   logic [15:0] unit_data;
   logic       mat_hit;

   always_comb
   begin
      state_next    = state_reg;
      cur_next      = cur_reg;
      last_next     = last_reg;
      bus_next      = bus_reg;
      data_next     = data_reg;
      eop_seen_next = eop_seen_reg | (busy & end_of_process[cur_reg]);  // RQ6
      accept        = 1'b0;
      err_start     = 1'b0;
      unit_done     = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            eop_seen_next = 1'b0;
            if (any_ready)
            begin
               if (cfg_reg[pick].cnt == 16'h0000)
                  err_start = 1'b1;                                  // RQ7
               else
               begin
                  accept     = 1'b1;
                  cur_next   = pick;
                  state_next = ST_READ;
                  bus_next   = first_cycle(cfg_reg[pick].sa, cfg_reg[pick].da, cfg_reg[pick].mode_a);
               end
            end
         end
         ST_READ:
         begin
            if (bus_ready)
            begin
               data_next = bus_rdata;
               if (single)
                  unit_done = 1'b1;
               else
               begin
                  state_next     = ST_WRITE;
                  bus_next.addr  = cur_cfg.da;                       // RQ11
                  bus_next.wdata = bus_rdata;
                  bus_next.write = 1'b1;
                  bus_next.wide  = cur_cfg.mode_a[MA_DST16];
               end
            end
         end
         ST_WRITE:
         begin
            if (bus_ready)
               unit_done = 1'b1;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase

      // end of a unit: events decide whether the channel goes on
      unit_data = (state_reg == ST_READ) ? bus_rdata : data_reg;
      mat_hit   = src16 ? (unit_data == cur_cfg.mat) :               // RQ19
                          (unit_data[7:0] == cur_cfg.mat[7:0]);      // RQ20
      ev        = 4'h0;
      if (unit_done)
      begin
         ev[FL_MAT] = mat_hit;                                       // RQ4
         ev[FL_TC]  = (cur_cfg.cnt == 16'h0001);                     // RQ5
         ev[FL_EOP] = eop_seen_next;                                 // RQ6
      end
      stop_now   = |ev;
      reload_now = stop_now & cur_cfg.cmd[CMD_RELOAD] &
                   |(ev & cur_cfg.cmd[CMD_IE_LSB +: 4]);             // RQ24
      if (unit_done)
      begin
         if (!stop_now && (xmode == XM_CONTINUE ||
                           (xmode == XM_DEMAND && req_line[cur_reg])))
         begin
            state_next    = ST_READ;
            bus_next      = first_cycle(nsa, nda, cur_cfg.mode_a);
            eop_seen_next = 1'b0;
         end
         else
         begin
            state_next = ST_IDLE;                                    // byte mode re-arbitrates
            last_next  = cur_reg;                                    // RQ2
         end
      end
   end

   // ****************************************
   // apb decode
   // ****************************************
   wire [1:0] a_ch     = paddr[CH_LSB +: 2];
   wire [3:0] a_idx    = paddr[IDX_LSB +: 4];
   wire       a_hi_ok  = (APB_AW == 8) ? 1'b1 : (paddr[APB_AW-1:CH_LSB] >> 2) == '0;
   wire       a_mapped = a_hi_ok & (a_idx <= IDX_FLAGS);
   wire       apb_wr   = psel & penable & pwrite & a_mapped;
   wire [7:0] wb       = pwdata[7:0];
   chan_cfg_type rd_cfg;
   logic [7:0]   rd_byte;
   assign rd_cfg = cfg_reg[a_ch];

   // read mux; read data is latched in the setup phase
   always_comb
   begin
      case (a_idx)
         IDX_SRC_LOW:  rd_byte = rd_cfg.sa[7:0];                     // RQ17
         IDX_SRC_MID:  rd_byte = rd_cfg.sa[15:8];
         IDX_SRC_HIGH: rd_byte = rd_cfg.sa[23:16];
         IDX_DST_LOW:  rd_byte = rd_cfg.da[7:0];
         IDX_DST_MID:  rd_byte = rd_cfg.da[15:8];
         IDX_DST_HIGH: rd_byte = rd_cfg.da[23:16];
         IDX_CNT_LOW:  rd_byte = rd_cfg.cnt[7:0];                    // RQ18
         IDX_CNT_HIGH: rd_byte = rd_cfg.cnt[15:8];
         IDX_MAT_LOW:  rd_byte = rd_cfg.mat[7:0];
         IDX_MAT_HIGH: rd_byte = rd_cfg.mat[15:8];
         IDX_MODE_A:   rd_byte = rd_cfg.mode_a;
         IDX_MODE_B:   rd_byte = rd_cfg.mode_b;
         IDX_CMD:      rd_byte = rd_cfg.cmd;
         IDX_FLAGS:    rd_byte = {3'h0, req_line[a_ch], flag_reg[a_ch]};
         default:      rd_byte = 8'h00;
      endcase
      prdata_next = prdata_reg;
      if (psel && !penable)
         prdata_next = a_mapped ? {24'h000000, rd_byte} : 32'h00000000;
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~a_mapped;

   // ****************************************
   // per channel register next values
   // ****************************************
   for (genvar c = 0; c < 4; c++)
   begin : g_chan
      wire hit  = apb_wr & (a_ch == 2'(c));
      wire mine = (cur_reg == 2'(c));
      wire took = (accept | err_start) & (pick == 2'(c));

      always_comb
      begin
         cfg_next[c]  = cfg_reg[c];
         shad_next[c] = shad_reg[c];
         flag_next[c] = flag_reg[c];
         pend_next[c] = pend_reg[c] | (req_src[c] & ~prev_reg[c]);
         tc_next[c]   = unit_done & mine & ev[FL_TC];
         if (took)
         begin
            pend_next[c]            = req_src[c] & ~prev_reg[c];  // a new edge here survives
            cfg_next[c].cmd[CMD_SW] = 1'b0;                          // RQ25
         end
         if (err_start && pick == 2'(c))
            cfg_next[c].cmd[CMD_EN] = 1'b0;                          // RQ7
         if (unit_done && mine)
         begin
            cfg_next[c].sa  = nsa;
            cfg_next[c].da  = nda;
            cfg_next[c].cnt = ncnt;                                  // RQ19
            if (reload_now)
            begin
               cfg_next[c].sa  = shad_reg[c].sa;                     // RQ26
               cfg_next[c].da  = shad_reg[c].da;
               cfg_next[c].cnt = shad_reg[c].cnt;
            end
            else if (stop_now)
               cfg_next[c].cmd[CMD_EN] = 1'b0;
         end
         // software writes to pointers and count load both the working copy and the reload copy
         if (hit)
         begin
            case (a_idx)
               IDX_SRC_LOW:  begin cfg_next[c].sa[7:0]   = wb; shad_next[c].sa[7:0]   = wb; end
               IDX_SRC_MID:  begin cfg_next[c].sa[15:8]  = wb; shad_next[c].sa[15:8]  = wb; end
               IDX_SRC_HIGH: begin cfg_next[c].sa[23:16] = wb; shad_next[c].sa[23:16] = wb; end
               IDX_DST_LOW:  begin cfg_next[c].da[7:0]   = wb; shad_next[c].da[7:0]   = wb; end
               IDX_DST_MID:  begin cfg_next[c].da[15:8]  = wb; shad_next[c].da[15:8]  = wb; end
               IDX_DST_HIGH: begin cfg_next[c].da[23:16] = wb; shad_next[c].da[23:16] = wb; end
               IDX_CNT_LOW:  begin cfg_next[c].cnt[7:0]  = wb; shad_next[c].cnt[7:0]  = wb; end
               IDX_CNT_HIGH: begin cfg_next[c].cnt[15:8] = wb; shad_next[c].cnt[15:8] = wb; end
               IDX_MAT_LOW:  cfg_next[c].mat[7:0]  = wb;
               IDX_MAT_HIGH: cfg_next[c].mat[15:8] = wb;
               IDX_MODE_A:   cfg_next[c].mode_a    = wb;
               IDX_MODE_B:   cfg_next[c].mode_b    = wb;
               IDX_CMD:      cfg_next[c].cmd       = wb;
               IDX_FLAGS:    flag_next[c]          = flag_reg[c] & ~wb[3:0];  // RQ8
               default:      flag_next[c]          = flag_reg[c];
            endcase
         end
         // set after clear so an event in the clearing cycle survives
         if (unit_done && mine)
            flag_next[c] = flag_next[c] | ev;                        // RQ8
         if (err_start && pick == 2'(c))
            flag_next[c][FL_ERR] = 1'b1;                             // RQ7 RQ8
      end

      always_ff @(posedge clk)
      begin
         if (!nrst)
         begin
            cfg_reg[c]  <= CFG_RST;
            shad_reg[c] <= CFG_RST;
            flag_reg[c] <= FLAGS_RST;
         end
         else
         begin
            cfg_reg[c]  <= cfg_next[c];
            shad_reg[c] <= shad_next[c];
            flag_reg[c] <= flag_next[c];
         end
      end

      // enabled events only reach the interrupt line
      assign event_irq[c] = |(flag_reg[c] & cfg_reg[c].cmd[CMD_IE_LSB +: 4]);  // RQ3
   end

   // ****************************************
   // engine and bus registers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state_reg    <= ST_IDLE;
         cur_reg      <= 2'h0;
         last_reg     <= 2'h3;
         bus_reg      <= BUS_RST;
         data_reg     <= 16'h0000;
         eop_seen_reg <= 1'b0;
         pend_reg     <= 4'h0;
         prev_reg     <= 4'h0;
         tc_reg       <= 4'h0;
         prdata_reg   <= 32'h00000000;
      end
      else
      begin
         state_reg    <= state_next;
         cur_reg      <= cur_next;
         last_reg     <= last_next;
         bus_reg      <= bus_next;
         data_reg     <= data_next;
         eop_seen_reg <= eop_seen_next;
         pend_reg     <= pend_next;
         prev_reg     <= req_src;
         tc_reg       <= tc_next;
         prdata_reg   <= prdata_next;
      end
   end

   // ****************************************
   // outputs and acknowledges
   // ****************************************
   // channel 3 has no enable of its own and acts as if it were cleared
   wire ack_en   = (cur_reg != 2'd3) & cur_cfg.mode_a[MA_ACK_PRI];   // RQ9 RQ10
   wire int_conn = cur_cfg.mode_b[MB_INTCONN];
   wire [2:0] sel = cur_cfg.mode_b[MB_SEL_LSB +: 3];
   wire ext_ok   = int_conn ? ack_en : (single | ack_en);            // RQ12
   wire int_ok   = int_conn & single & (sel <= SEL_ACK_LAST);        // RQ13

   assign transfer_acknowledge = (busy && ext_ok) ? 4'(4'h1 << cur_reg) : 4'h0;
   assign internal_acknowledge = (busy && int_ok) ? 8'(8'h01 << sel) : 8'h00;
   assign terminal_count       = tc_reg;
   assign bus_req              = busy;
   assign bus_cmd              = bus_reg;

endmodule // dma_controller
`default_nettype wire

//--- tb/dma_controller_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module dma_controller_props
   import dma_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        pready,
   input wire logic [3:0]  transfer_acknowledge,
   input wire logic [7:0]  internal_acknowledge,
   input wire logic [3:0]  terminal_count,
   input wire logic        bus_req,
   input wire bus_cmd_type bus_cmd,
   input wire logic        bus_ready
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_tc_after_unit: assert property (|terminal_count |-> $past(bus_req && bus_ready))
      else $error("terminal count without a finished unit");
   a_tc_one_pulse: assert property (|terminal_count |=> (terminal_count & $past(terminal_count)) == 4'h0)
      else $error("terminal count longer than one cycle");
   a_cmd_held: assert property (bus_req && !bus_ready |=> bus_req && $stable(bus_cmd))
      else $error("bus cycle changed before ready");
   a_ack_in_unit: assert property (|transfer_acknowledge |-> bus_req)
      else $error("acknowledge outside a unit");
   a_ack_one_chan: assert property ($onehot0(transfer_acknowledge))
      else $error("acknowledge on two channels");
   a_no_timer_ack: assert property (internal_acknowledge[7:5] == 3'h0)
      else $error("internal acknowledge to a timer source");
   a_iack_in_unit: assert property (|internal_acknowledge |-> bus_req && $onehot0(internal_acknowledge))
      else $error("internal acknowledge outside a unit");
   a_reset_quiet: assert property ($rose(nrst) |-> !bus_req && terminal_count == 4'h0)
      else $error("engine active out of reset");
   a_ready_up: assert property (pready)
      else $error("apb ready dropped");
   c_tc: cover property (|terminal_count);
   c_ack: cover property (|transfer_acknowledge);
   c_slow: cover property (bus_req && !bus_ready ##1 bus_ready);
endmodule // dma_controller_props
`default_nettype wire

//--- tb/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// memory side
// ****
module mem_model
   import dma_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        bus_req,
   output logic             bus_ready,
   output logic [15:0]      bus_rdata
);
   logic [1:0] wait_reg;
   logic       slow_reg;
   // answers alternate prompt and slow; data off-cycle is inverted so it never looks valid
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         bus_ready <= 1'b0;
         wait_reg  <= 2'h0;
         slow_reg  <= 1'b0;
      end
      else
      begin
         bus_ready <= bus_req && !bus_ready && wait_reg == (slow_reg ? 2'h2 : 2'h0);
         wait_reg  <= (bus_req && !bus_ready) ? wait_reg + 2'h1 : 2'h0;
         slow_reg  <= bus_ready ? ~slow_reg : slow_reg;
      end
   end
   assign bus_rdata = bus_ready ? 16'h00a5 : 16'hff5a;
endmodule // mem_model
`default_nettype wire

//--- tb/dma_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_controller_tb;
   import dma_pkg::*;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, bus_req, bus_ready, perr;
   logic [7:0]  paddr = 0, internal_request = 0, internal_acknowledge;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic [3:0]  transfer_request_pin = 0, end_of_process = 0, transfer_acknowledge, terminal_count, event_irq;
   logic [15:0] bus_rdata;
   bus_cmd_type bus_cmd;
   int bad_count = 0, n_checks = 0;
   dma_controller u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .transfer_request_pin(transfer_request_pin), .end_of_process(end_of_process),
      .internal_request(internal_request), .transfer_acknowledge(transfer_acknowledge),
      .internal_acknowledge(internal_acknowledge), .terminal_count(terminal_count), .event_irq(event_irq),
      .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ready(bus_ready), .bus_rdata(bus_rdata));
   mem_model u_mem (.clk(clk), .nrst(nrst), .bus_req(bus_req), .bus_ready(bus_ready), .bus_rdata(bus_rdata));
   // ****
   // bus tasks
   // ****
   function automatic logic [7:0] ad(input logic [1:0] c, input logic [3:0] i);
      return {c, i, 2'b00};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // setup then access, held until ready is seen high
   task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin bad_count++; stop_test; end
      rdat = prdata;
      perr = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // 0 terminal count, 1 acknowledge, 2 interrupt, 3 bus request
   task automatic wt(input int s);
      int n;
      logic v;
      n = 0;
      do begin
         @(posedge clk); #1; n++;
         v = s == 0 ? |terminal_count : s == 1 ? |transfer_acknowledge : s == 2 ? |event_irq : bus_req;
      end while (v !== 1'b1 && n < 200);
      if (v !== 1'b1) begin bad_count++; stop_test; end
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_error;
      xf(1, ad(3, IDX_CNT_LOW), 8'h00); xf(1, ad(3, IDX_CMD), 8'h83);
      xf(0, ad(3, IDX_CNT_LOW), 8'h00); ck(rdat, 32'h0);
      xf(0, ad(3, IDX_FLAGS), 8'h00); ck(rdat, 32'h8);
      ck({28'h0, event_irq}, 32'h8);
      xf(1, ad(3, IDX_FLAGS), 8'h08); xf(0, ad(3, IDX_FLAGS), 8'h00); ck(rdat, 32'h0);
      xf(0, 8'h38, 8'h00); ck(rdat, 32'h0);
      ck({31'h0, perr}, 32'h1);
   endtask
   task automatic t_match;
      xf(1, ad(0, IDX_SRC_LOW), 8'h10); xf(1, ad(0, IDX_DST_LOW), 8'h20); xf(1, ad(0, IDX_CNT_LOW), 8'h03);
      xf(1, ad(0, IDX_MAT_LOW), 8'ha5); xf(1, ad(0, IDX_MAT_HIGH), 8'h77); xf(1, ad(0, IDX_CMD), 8'h13);
      wt(2);
      xf(0, ad(0, IDX_FLAGS), 8'h00); ck(rdat, 32'h1);
      xf(1, ad(0, IDX_FLAGS), 8'h01);
   endtask
   task automatic t_count;
      xf(1, ad(0, IDX_CNT_LOW), 8'h01); xf(1, ad(0, IDX_MAT_LOW), 8'h3c); xf(1, ad(0, IDX_CMD), 8'h2b);
      wt(3); ck({8'h0, bus_cmd.addr}, 32'h10);
      wt(0);
      xf(0, ad(0, IDX_FLAGS), 8'h00); ck(rdat, 32'h2);
      xf(0, ad(0, IDX_CNT_LOW), 8'h00); ck(rdat, 32'h1);
   endtask
   task automatic t_prio;
      for (int c = 1; c < 3; c++)
      begin
         xf(1, ad(c[1:0], IDX_MODE_A), 8'h80); xf(1, ad(c[1:0], IDX_CNT_LOW), 8'h01);
         xf(1, ad(c[1:0], IDX_CMD), 8'h01);
      end
      @(posedge clk) transfer_request_pin <= 4'b0110;
      wt(1); ck({28'h0, transfer_acknowledge}, 32'h2);
      wt(0);
   endtask
   // clock and main sequence
   initial begin clk = 0; forever #12.5 clk = ~clk; end
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      t_error; t_match; t_count; t_prio;
      stop_test;
   end
endmodule // dma_controller_tb
bind dma_controller dma_controller_props u_props (.clk(clk), .nrst(nrst), .pready(pready),
   .transfer_acknowledge(transfer_acknowledge), .internal_acknowledge(internal_acknowledge),
   .terminal_count(terminal_count), .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ready(bus_ready));
`default_nettype wire
